// ### verilog/line_alarm_pkg.sv
// constants for the line alarm and interrupt status block
package line_alarm_pkg;

  // ****************************************
  // bus and register geometry
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned IDX_W = 6;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ENABLE = 6'h01;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h02;
  localparam logic [IDX_W-1:0] IDX_ALARM = 6'h03;
  localparam logic [IDX_W-1:0] IDX_JA_CTRL = 6'h07;
  localparam logic [IDX_W-1:0] IDX_CLEAR = 6'h08;
  localparam logic [IDX_W-1:0] IDX_CNT_MSB = 6'h30;
  localparam logic [IDX_W-1:0] IDX_CNT_LSB = 6'h31;

  // ****************************************
  // field positions (status, enable and clear share one layout)
  // ****************************************
  localparam int unsigned BIT_DRV = 0;
  localparam int unsigned BIT_RXLOS = 1;
  localparam int unsigned BIT_UNLOCK = 2;
  localparam int unsigned BIT_FIFO = 3;
  localparam int unsigned BIT_PAT = 4;
  localparam int unsigned BIT_CNT = 5;
  localparam int unsigned BIT_ANALOG = 4;
  localparam int unsigned BIT_DIGITAL = 5;
  localparam int unsigned BIT_JA_EN = 0;
  localparam logic [REG_W-1:0] EVENT_MASK = 8'h3f;
  localparam logic [REG_W-1:0] ENABLE_MASK = 8'h3f;
  localparam logic [REG_W-1:0] JA_CTRL_MASK = 8'h01;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [REG_W-1:0] RST_ENABLE = 8'h00;
  localparam logic [REG_W-1:0] RST_STATUS = 8'h00;
  localparam logic [REG_W-1:0] RST_ALARM = 8'h00;
  localparam logic [REG_W-1:0] RST_JA_CTRL = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  // ****************************************
  // counts
  // ****************************************
  localparam int unsigned SILENT_BITS = 128;
  localparam logic [7:0] SILENT_LIMIT = 8'h80;
  localparam logic [15:0] COUNT_FULL = 16'hffff;
  localparam int unsigned FIFO_MARGIN_BITS = 2;

endpackage

// ### verilog/line_alarm_interrupt_status.sv
// alarm flags, change events and interrupt request of the line interface, on an apb slave
//
// How it works
// - pattern error enable gates pattern error interrupt
// - driver alarm change sets its flag
// - receive loss change sets its flag
// - unlock change sets its flag
// - fifo margin change sets its flag
// - pattern error sets pattern error flag
// - counter saturation sets counter full flag
// - reading event flags clears them
// - 128 silent bit periods raise driver alarm
// - receive loss alarm follows receiver
// - unlock alarm follows receiver
// - fifo within two bits raises margin alarm
// - analog loss alarm follows receiver
// - digital loss alarm follows receiver
// - receive loss enable gates its interrupt
// - fifo margin enable ignored without attenuator
//
// The APB slave port was left to the implementer.
module line_alarm_interrupt_status
#(
  parameter int unsigned FIFO_DEPTH = 32,
  parameter int unsigned FILL_W = 8
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [line_alarm_pkg::ADDR_W-1:0] paddr,
  input wire logic [line_alarm_pkg::DATA_W-1:0] pwdata,
  output logic [line_alarm_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // line side conditions
  input wire logic bit_tick,
  input wire logic monitor_in_pos,
  input wire logic monitor_in_neg,
  input wire logic rx_signal_loss,
  input wire logic rx_unlock,
  input wire logic [FILL_W-1:0] fifo_fill,
  input wire logic analog_signal_loss,
  input wire logic digital_signal_loss,
  input wire logic pattern_error,
  // results
  output logic irq,
  output logic driver_fail_alarm,
  output logic counter_full
);
  import line_alarm_pkg::*;

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
    hit = (addr[ADDR_W-1:2] == idx);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    mapped = hit(addr, IDX_ENABLE) | hit(addr, IDX_STATUS) | hit(addr, IDX_ALARM) |
             hit(addr, IDX_JA_CTRL) | hit(addr, IDX_CLEAR) | hit(addr, IDX_CNT_MSB) |
             hit(addr, IDX_CNT_LSB);
  endfunction

  localparam logic [FILL_W-1:0] FILL_LOW = FILL_W'(FIFO_MARGIN_BITS);
  localparam logic [FILL_W-1:0] FILL_HIGH = FILL_W'(FIFO_DEPTH - FIFO_MARGIN_BITS);

  logic setup;
  logic access;
  logic rd_status;
  logic wr_enable;
  logic wr_ja_ctrl;
  logic wr_clear;
  logic wr_count;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign rd_status = access & ~pwrite & hit(paddr, IDX_STATUS);
  assign wr_enable = access & pwrite & hit(paddr, IDX_ENABLE);
  assign wr_ja_ctrl = access & pwrite & hit(paddr, IDX_JA_CTRL);
  assign wr_clear = access & pwrite & hit(paddr, IDX_CLEAR);
  assign wr_count = access & pwrite & hit(paddr, IDX_CNT_MSB);

  // ****************************************
  // state
  // ****************************************
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [REG_W-1:0] enable_reg;
  logic [REG_W-1:0] enable_next;
  logic [REG_W-1:0] ja_ctrl_reg;
  logic [REG_W-1:0] ja_ctrl_next;
  logic [7:0] silent_reg;
  logic [7:0] silent_next;
  logic [REG_W-1:0] alarm_reg;
  logic [REG_W-1:0] alarm_next;
  logic [REG_W-1:0] status_reg;
  logic [REG_W-1:0] status_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [REG_W-1:0] event_now;
  logic [REG_W-1:0] clear_bits;
  logic [REG_W-1:0] live_enable;

  // ****************************************
  // bus and configuration
  // ****************************************
  // read data is captured in the setup cycle so the access phase sees a flop;
  // pready is always high, so every transfer ends in its first access cycle
  always_comb
  begin
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    enable_next = enable_reg;
    ja_ctrl_next = ja_ctrl_reg;
    if (setup)
    begin
      pslverr_next = ~mapped(paddr);
      prdata_next = '0;
      if (!pwrite)
      begin
        if (hit(paddr, IDX_ENABLE))
          prdata_next[REG_W-1:0] = enable_reg;
        else if (hit(paddr, IDX_STATUS))
          prdata_next[REG_W-1:0] = status_reg;
        else if (hit(paddr, IDX_ALARM))
          prdata_next[REG_W-1:0] = alarm_reg;
        else if (hit(paddr, IDX_JA_CTRL))
          prdata_next[REG_W-1:0] = ja_ctrl_reg;
        else if (hit(paddr, IDX_CNT_MSB))
          prdata_next[REG_W-1:0] = count_reg[15:8];
        else if (hit(paddr, IDX_CNT_LSB))
          prdata_next[REG_W-1:0] = count_reg[7:0];
      end
    end
    if (wr_enable)
      enable_next = pwdata[REG_W-1:0] & ENABLE_MASK;
    if (wr_ja_ctrl)
      ja_ctrl_next = pwdata[REG_W-1:0] & JA_CTRL_MASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
      enable_reg <= RST_ENABLE;
      ja_ctrl_reg <= RST_JA_CTRL;
    end
    else
    begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      enable_reg <= enable_next;
      ja_ctrl_reg <= ja_ctrl_next;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign pready = 1'b1;

  // ****************************************
  // alarms, events and error counter
  // ****************************************
  always_comb
  begin
    silent_next = silent_reg;
    if (monitor_in_pos | monitor_in_neg)
      silent_next = '0;
    else if (bit_tick && silent_reg != SILENT_LIMIT)
      silent_next = silent_reg + 8'h01;

    alarm_next = RST_ALARM;
    alarm_next[BIT_DRV] = (silent_next == SILENT_LIMIT);
    alarm_next[BIT_RXLOS] = rx_signal_loss;
    alarm_next[BIT_UNLOCK] = rx_unlock;
    alarm_next[BIT_FIFO] = (fifo_fill <= FILL_LOW) | (fifo_fill >= FILL_HIGH);
    alarm_next[BIT_ANALOG] = analog_signal_loss;
    alarm_next[BIT_DIGITAL] = digital_signal_loss;

    count_next = count_reg;
    if (wr_count)
      count_next = RST_COUNT;
    else if (pattern_error && count_reg != COUNT_FULL)
      count_next = count_reg + 16'h0001;

    event_now = '0;
    event_now[BIT_DRV] = alarm_next[BIT_DRV] ^ alarm_reg[BIT_DRV];
    event_now[BIT_RXLOS] = alarm_next[BIT_RXLOS] ^ alarm_reg[BIT_RXLOS];
    event_now[BIT_UNLOCK] = alarm_next[BIT_UNLOCK] ^ alarm_reg[BIT_UNLOCK];
    event_now[BIT_FIFO] = alarm_next[BIT_FIFO] ^ alarm_reg[BIT_FIFO];
    event_now[BIT_PAT] = pattern_error;
    event_now[BIT_CNT] = (count_next == COUNT_FULL) && (count_reg != COUNT_FULL);

    // only the bits actually returned are cleared, so a flag set between the
    // setup capture and the access edge is not thrown away
    clear_bits = '0;
    if (rd_status)
      clear_bits = prdata_reg[REG_W-1:0];
    if (wr_clear)
      clear_bits = clear_bits | pwdata[REG_W-1:0];
    status_next = ((status_reg & ~clear_bits) | event_now) & EVENT_MASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      silent_reg <= '0;
      alarm_reg <= RST_ALARM;
      count_reg <= RST_COUNT;
      status_reg <= RST_STATUS;
    end
    else
    begin
      silent_reg <= silent_next;
      alarm_reg <= alarm_next;
      count_reg <= count_next;
      status_reg <= status_next;
    end
  end

  // ****************************************
  // interrupt request
  // ****************************************
  // fifo margin enable has no effect while the attenuator is off
  always_comb
  begin
    live_enable = enable_reg;
    live_enable[BIT_FIFO] = enable_reg[BIT_FIFO] & ja_ctrl_reg[BIT_JA_EN];
  end

  assign irq = |(status_reg & live_enable);
  assign driver_fail_alarm = alarm_reg[BIT_DRV];
  assign counter_full = (count_reg == COUNT_FULL);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_pat_irq;
    (status_reg[BIT_PAT] && enable_reg[BIT_PAT]) |-> irq;
  endproperty
  a_pat_irq: assert property (p_pat_irq) else $error("pattern error flag enabled but no irq");

  property p_cnt_irq;
    (pattern_error && count_reg == 16'hfffe && !wr_count && enable_reg[BIT_CNT] && !wr_enable) |=> irq;
  endproperty
  a_cnt_irq: assert property (p_cnt_irq) else $error("saturation gave no irq");

  property p_drv_change;
    $changed(alarm_reg[BIT_DRV]) |-> status_reg[BIT_DRV];
  endproperty
  a_drv_change: assert property (p_drv_change) else $error("driver alarm change not flagged");

  property p_rxlos_change;
    $changed(alarm_reg[BIT_RXLOS]) |-> status_reg[BIT_RXLOS];
  endproperty
  a_rxlos_change: assert property (p_rxlos_change) else $error("receive loss change not flagged");

  property p_unlock_change;
    $changed(alarm_reg[BIT_UNLOCK]) |-> status_reg[BIT_UNLOCK];
  endproperty
  a_unlock_change: assert property (p_unlock_change) else $error("unlock change not flagged");

  property p_fifo_change;
    $changed(alarm_reg[BIT_FIFO]) |-> status_reg[BIT_FIFO];
  endproperty
  a_fifo_change: assert property (p_fifo_change) else $error("fifo margin change not flagged");

  property p_pat_flag;
    pattern_error |=> status_reg[BIT_PAT];
  endproperty
  a_pat_flag: assert property (p_pat_flag) else $error("pattern error not flagged");

  property p_sat_flag;
    (pattern_error && count_reg == 16'hfffe && !wr_count) |=> (counter_full && status_reg[BIT_CNT]);
  endproperty
  a_sat_flag: assert property (p_sat_flag) else $error("saturation not flagged");

  property p_read_clear;
    (rd_status && event_now == 8'h00 && !wr_clear) |=> ((status_reg & $past(prdata_reg[7:0])) == 8'h00);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear flags");

  property p_silent;
    (silent_reg == 8'h7f && bit_tick && !monitor_in_pos && !monitor_in_neg) |=> driver_fail_alarm;
  endproperty
  a_silent: assert property (p_silent) else $error("driver alarm missing after silent bits");

  property p_pulse_quiet;
    (monitor_in_pos || monitor_in_neg) |=> !driver_fail_alarm;
  endproperty
  a_pulse_quiet: assert property (p_pulse_quiet) else $error("driver alarm despite pulse");

  property p_rxlos;
    rx_signal_loss |=> alarm_reg[BIT_RXLOS];
  endproperty
  a_rxlos: assert property (p_rxlos) else $error("receive loss alarm wrong");

  property p_unlock;
    rx_unlock |=> alarm_reg[BIT_UNLOCK];
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock alarm wrong");

  property p_margin;
    (fifo_fill > FILL_LOW && fifo_fill < FILL_HIGH) |=> !alarm_reg[BIT_FIFO];
  endproperty
  a_margin: assert property (p_margin) else $error("fifo margin alarm wrong");

  property p_analog;
    analog_signal_loss |=> alarm_reg[BIT_ANALOG];
  endproperty
  a_analog: assert property (p_analog) else $error("analog loss alarm wrong");

  property p_digital;
    !digital_signal_loss |=> !alarm_reg[BIT_DIGITAL];
  endproperty
  a_digital: assert property (p_digital) else $error("digital loss alarm wrong");

  property p_rxlos_irq;
    (!enable_reg[BIT_RXLOS] && (status_reg & live_enable & 8'h3d) == 8'h00) |-> !irq;
  endproperty
  a_rxlos_irq: assert property (p_rxlos_irq) else $error("irq with receive loss disabled");

  property p_ja_off;
    (!ja_ctrl_reg[BIT_JA_EN] && (status_reg & enable_reg & 8'h37) == 8'h00) |-> !irq;
  endproperty
  a_ja_off: assert property (p_ja_off) else $error("fifo margin irq with attenuator off");

  // a flag raised after the setup capture is not returned, so it keeps irq up
  property p_irq_release;
    (irq && rd_status && (status_reg & ~prdata_reg[REG_W-1:0]) == 8'h00 &&
     !wr_enable && !wr_ja_ctrl && event_now == 8'h00) |=> !irq;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("irq held after flags cleared");

  property p_keep_event;
    (event_now != 8'h00) |=> ((status_reg & $past(event_now)) == $past(event_now));
  endproperty
  a_keep_event: assert property (p_keep_event) else $error("event lost");

  // saturation is sticky: only a write to the count msb register moves the counter off all ones
  property p_sat_hold;
    (counter_full && !wr_count) |=> counter_full;
  endproperty
  a_sat_hold: assert property (p_sat_hold) else $error("counter left saturation");

  property p_fifo_edge;
    (fifo_fill <= FILL_LOW || fifo_fill >= FILL_HIGH) |=> alarm_reg[BIT_FIFO];
  endproperty
  a_fifo_edge: assert property (p_fifo_edge) else $error("fifo margin alarm missing");

  property p_unlock_off;
    !rx_unlock |=> !alarm_reg[BIT_UNLOCK];
  endproperty
  a_unlock_off: assert property (p_unlock_off) else $error("unlock alarm without unlock");

  c_read_clear: cover property (rd_status && prdata_reg[7:0] != 8'h00 ##1 status_reg == 8'h00);
  c_event_in_read: cover property (rd_status && event_now != 8'h00);
  c_saturate: cover property (pattern_error && count_reg == 16'hfffe);
  c_driver_alarm: cover property ($rose(driver_fail_alarm) ##[1:4] irq);
  c_fifo_irq: cover property ($rose(irq) && ja_ctrl_reg[BIT_JA_EN] && status_reg[BIT_FIFO]);

endmodule

// ### verification/tb_line_alarm_interrupt_status.sv
// self-checking bench for the line alarm and interrupt status block
module tb_line_alarm_interrupt_status;
  timeunit 1ns;
  timeprecision 1ns;
  import line_alarm_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bit_tick = 1'b0;
  logic mon_pos = 1'b0;
  logic mon_neg = 1'b0;
  logic [3:0] lvl = 4'h0;
  logic [7:0] fill = 8'h10;
  logic pat = 1'b0;
  logic irq;
  logic drv;
  logic cfull;
  logic [32:0] exp_q[$];
  int error_cnt = 0;
  int compares = 0;
  int seed = 41261;
  localparam logic [7:0] A_EN = {IDX_ENABLE, 2'b00};
  localparam logic [7:0] A_ST = {IDX_STATUS, 2'b00};
  localparam logic [7:0] A_AL = {IDX_ALARM, 2'b00};
  localparam logic [7:0] A_JA = {IDX_JA_CTRL, 2'b00};
  localparam logic [7:0] A_CLR = {IDX_CLEAR, 2'b00};
  localparam logic [7:0] A_CM = {IDX_CNT_MSB, 2'b00};
  localparam logic [7:0] A_CL = {IDX_CNT_LSB, 2'b00};

  always #25 pclk = ~pclk;

  line_alarm_interrupt_status dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_tick(bit_tick), .monitor_in_pos(mon_pos), .monitor_in_neg(mon_neg),
    .rx_signal_loss(lvl[0]), .rx_unlock(lvl[1]), .fifo_fill(fill),
    .analog_signal_loss(lvl[2]), .digital_signal_loss(lvl[3]), .pattern_error(pat),
    .irq(irq), .driver_fail_alarm(drv), .counter_full(cfull)
  );

  // ****************************************
  // tasks
  // ****************************************
  task cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wrap_up;
    $display("counts: compares=%0d mismatches=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // expectation is queued at setup; the monitor pops it at the access edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr)
      exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] v);
    apb(1'b0, a, 32'h0, {25'h0, v});
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h0, v}, 33'h0);
  endtask

  task idle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task ticks(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      bit_tick <= 1'b1;
      @(posedge pclk);
      bit_tick <= 1'b0;
    end
  endtask

  task lvl_chk(input string nm, input logic e, input logic g);
    cmp(nm, {32'h0, e}, {32'h0, g});
  endtask

  // ****************************************
  // read monitor
  // ****************************************
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      if (exp_q.size() == 0)
        cmp("unexpected read", 33'h0, 33'h1);
      else
        cmp("read data", exp_q.pop_front(), {pslverr, prdata});
    end
  end

  initial
  begin
    #(90000 * 50);
    error_cnt++;
    wrap_up();
  end

  // ****************************************
  // tests
  // ****************************************
  initial
  begin : main
    int ab[4];
    logic [7:0] sb[4];
    logic [7:0] ff[4];
    logic [7:0] ea[4];
    logic [7:0] es[4];
    logic [31:0] v;
    ab = '{BIT_RXLOS, BIT_UNLOCK, BIT_ANALOG, BIT_DIGITAL};
    sb = '{8'h02, 8'h04, 8'h00, 8'h00};
    ff = '{8'h03, 8'h02, 8'h1d, 8'h1e};
    ea = '{8'h00, 8'h08, 8'h00, 8'h08};
    es = '{8'h00, 8'h08, 8'h08, 8'h08};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_EN, RST_ENABLE);
    rd(A_ST, RST_STATUS);
    rd(A_AL, RST_ALARM);
    lvl_chk("irq", 1'b0, irq);
    v = $random(seed);
    wr(A_EN, v[7:0]);
    rd(A_EN, v[7:0] & ENABLE_MASK);
    wr(A_EN, 8'h00);
    apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
    $display("test reset and registers done");
    for (int i = 0; i < 4; i++)
    begin
      lvl <= 4'(1 << i);
      idle(2);
      rd(A_AL, 8'(1 << ab[i]));
      rd(A_ST, sb[i]);
      rd(A_ST, 8'h00);
      lvl <= 4'h0;
      idle(2);
      rd(A_ST, sb[i]);
    end
    wr(A_EN, 8'h02);
    lvl <= 4'h1;
    idle(2);
    lvl_chk("irq", 1'b1, irq);
    rd(A_ST, 8'h02);
    #1;
    lvl_chk("irq", 1'b0, irq);
    wr(A_EN, 8'h00);
    lvl <= 4'h0;
    idle(2);
    lvl_chk("irq", 1'b0, irq);
    rd(A_ST, 8'h02);
    $display("test receiver alarms done");
    for (int i = 0; i < 4; i++)
    begin
      fill <= ff[i];
      idle(2);
      rd(A_AL, ea[i]);
      rd(A_ST, es[i]);
    end
    wr(A_EN, 8'h08);
    fill <= 8'h10;
    idle(2);
    lvl_chk("irq", 1'b0, irq);
    wr(A_JA, 8'h01);
    #1;
    lvl_chk("irq", 1'b1, irq);
    rd(A_ST, 8'h08);
    wr(A_EN, 8'h00);
    wr(A_JA, 8'h00);
    $display("test fifo margin done");
    ticks(SILENT_BITS - 1);
    idle(2);
    lvl_chk("driver alarm", 1'b0, drv);
    ticks(1);
    idle(2);
    lvl_chk("driver alarm", 1'b1, drv);
    rd(A_AL, 8'h01);
    rd(A_ST, 8'h01);
    mon_neg <= 1'b1;
    @(posedge pclk);
    mon_neg <= 1'b0;
    idle(2);
    lvl_chk("driver alarm", 1'b0, drv);
    ticks(100);
    @(posedge pclk);
    mon_pos <= 1'b1;
    @(posedge pclk);
    mon_pos <= 1'b0;
    ticks(100);
    idle(2);
    lvl_chk("driver alarm", 1'b0, drv);
    rd(A_ST, 8'h01);
    $display("test driver monitor done");
    wr(A_EN, 8'h10);
    pat <= 1'b1;
    @(posedge pclk);
    pat <= 1'b0;
    idle(2);
    lvl_chk("irq", 1'b1, irq);
    wr(A_CLR, 8'h10);
    #1;
    lvl_chk("irq", 1'b0, irq);
    fork
      rd(A_ST, 8'h00);
      begin
        repeat (2) @(posedge pclk);
        pat <= 1'b1;
        @(posedge pclk);
        pat <= 1'b0;
      end
    join
    rd(A_ST, 8'h10);
    wr(A_CM, 8'h00);
    wr(A_EN, 8'h20);
    pat <= 1'b1;
    repeat (65534) @(posedge pclk);
    pat <= 1'b0;
    idle(2);
    lvl_chk("counter full", 1'b0, cfull);
    lvl_chk("irq", 1'b0, irq);
    rd(A_CM, 8'hff);
    rd(A_CL, 8'hfe);
    pat <= 1'b1;
    @(posedge pclk);
    pat <= 1'b0;
    idle(2);
    lvl_chk("counter full", 1'b1, cfull);
    lvl_chk("irq", 1'b1, irq);
    rd(A_ST, 8'h30);
    wr(A_CM, 8'h00);
    #1;
    lvl_chk("counter full", 1'b0, cfull);
    wr(A_EN, 8'h00);
    $display("test pattern errors done");
    idle(2);
    wrap_up();
  end
endmodule
